// ---- common/pdrlc_pkg.sv ----
// Shared constants, types and helpers for the DAC register bank and load control
package pdrlc_pkg;

    // Register targets of a host request
    typedef enum logic [2:0] {
        TGT_GAIN,
        TGT_OFFSET,
        TGT_INPUT,
        TGT_SYSCTL,
        TGT_CHANCFG,
        TGT_ALARM,
        TGT_COMPARE
    } pdrlc_target_type;

    // One host request per cycle
    typedef struct packed {
        logic valid;
        logic isWrite;
        pdrlc_target_type target;
        logic [5:0] addr;
        logic [21:0] data;
    } pdrlc_req_type;

    // Five level DACs of one channel
    typedef struct packed {
        logic [15:0] forceLevel;
        logic [15:0] clampLow;
        logic [15:0] clampHigh;
        logic [15:0] compareLow;
        logic [15:0] compareHigh;
    } pdrlc_dac_set_type;

    // Readback type codes
    localparam logic [1:0] RB_TYPE_GAIN = 2'h1;
    localparam logic [1:0] RB_TYPE_OFFSET = 2'h2;
    localparam logic [1:0] RB_TYPE_INPUT = 2'h3;

    // Slot kinds inside a channel (address bits 3:0)
    localparam logic [3:0] K_FIN_V = 4'h0;
    localparam logic [3:0] K_FIN_I0 = 4'h1;
    localparam logic [3:0] K_CLL_I = 4'h6;
    localparam logic [3:0] K_CLH_I = 4'h7;
    localparam logic [3:0] K_CLL_V = 4'h8;
    localparam logic [3:0] K_CLH_V = 4'h9;
    localparam logic [3:0] K_CPL_V = 4'ha;
    localparam logic [3:0] K_CPH_V = 4'hb;
    localparam logic [3:0] K_CPL_I = 4'hc;
    localparam logic [3:0] K_CPH_I = 4'hd;
    localparam logic [3:0] K_OFFSET_DAC = 4'he;
    localparam logic [2:0] MAX_CUR_RANGE = 3'h4;

    // Reset values
    localparam logic [15:0] GAIN_RST = 16'hffff;
    localparam logic [15:0] OFFSET_RST = 16'h8000;
    localparam logic [15:0] OFFSET_DAC_RST = 16'ha492;
    localparam logic [15:0] FIN_RST = 16'h8000;
    localparam logic [15:0] LOW_RST = 16'h0000;
    localparam logic [15:0] HIGH_RST = 16'hffff;
    localparam logic [23:0] ALARM_RST = 24'hfffff0;
    localparam logic [23:0] COMPARE_RST = 24'h400000;
    localparam logic [21:0] SYSCTL_RST = 22'h000020;
    localparam logic [21:0] CHANCFG_RST = 22'h01e060;

    // Field positions
    localparam int SYS_THERM_EN_BIT = 5;
    localparam int CFG_FSEL_HI = 20;
    localparam int CFG_FSEL_LO = 19;
    localparam int CFG_RANGE_HI = 17;
    localparam int CFG_RANGE_LO = 15;
    localparam int CFG_CLAMP_BIT = 9;
    localparam int CFG_CMP_I_BIT = 7;
    localparam int CFG_TALM_CLR_BIT = 6;
    localparam int CFG_TALM_LIVE_BIT = 5;
    localparam int ALM_LATCHED_BIT = 21;
    localparam int ALM_LIVE_BIT = 20;

    // Force select codes
    localparam logic [1:0] FSEL_FV = 2'h0;
    localparam logic [1:0] FSEL_FI = 2'h1;
    localparam logic [1:0] FSEL_HIZ_V = 2'h2;
    localparam logic [1:0] FSEL_HIZ_I = 2'h3;

    // Input code value after reset for a slot kind
    function automatic logic [15:0] x1Default(logic [3:0] kind);
        logic [15:0] value;
        value = LOW_RST;
        if (kind <= 4'h5) begin
            value = FIN_RST;
        end else if (kind == K_CLH_I || kind == K_CLH_V || kind == K_CPH_V || kind == K_CPH_I) begin
            value = HIGH_RST;
        end else if (kind == K_OFFSET_DAC) begin
            value = OFFSET_DAC_RST;
        end
        return value;
    endfunction

endpackage

// ---- design/pdrlc_cal_engine.sv ----
// Gain and offset correction of an input code
`timescale 1ns/1ps
`default_nettype none
module pdrlc_cal_engine (
    input wire logic [15:0] inputCode,
    input wire logic [15:0] gainCoef,
    input wire logic [15:0] offsetCoef,
    output logic [15:0] correctedCode
);
    logic [32:0] product; // Input times gain plus one
    logic signed [18:0] sum; // Scaled product plus offset less midscale

    always_comb begin
        product = 33'(inputCode) * 33'({1'b0, gainCoef} + 17'h00001);
        sum = $signed({2'b00, product[32:16]}) + $signed({3'b000, offsetCoef}) - 19'sh08000;
        // Saturate to the code range
        if (sum < 0) begin
            correctedCode = 16'h0000;
        end else if (sum > 19'sh0ffff) begin
            correctedCode = 16'hffff;
        end else begin
            correctedCode = sum[15:0];
        end
    end
endmodule // pdrlc_cal_engine
`default_nettype wire

// ---- design/pdrlc_readback.sv ----
// Readback word formatter, registered
`timescale 1ns/1ps
`default_nettype none
module pdrlc_readback (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic readReq,
    input wire pdrlc_pkg::pdrlc_target_type target,
    input wire logic [5:0] addr,
    input wire logic [23:0] rawWord,
    output logic [23:0] readbackData,
    output logic readbackValid
);
    logic [23:0] word; // Formatted word

    // Build the answer word
    always_comb begin
        unique case (target)
            pdrlc_pkg::TGT_GAIN: word = {pdrlc_pkg::RB_TYPE_GAIN, addr, rawWord[15:0]};
            pdrlc_pkg::TGT_OFFSET: word = {pdrlc_pkg::RB_TYPE_OFFSET, addr, rawWord[15:0]};
            pdrlc_pkg::TGT_INPUT: word = {pdrlc_pkg::RB_TYPE_INPUT, addr, rawWord[15:0]};
            pdrlc_pkg::TGT_SYSCTL, pdrlc_pkg::TGT_CHANCFG, pdrlc_pkg::TGT_ALARM,
            pdrlc_pkg::TGT_COMPARE: word = rawWord;
            // Unused target code reads zero
            default: word = 24'h000000;
        endcase
    end

    // Answer one cycle after the request
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            readbackData <= 24'h000000;
            readbackValid <= 1'b0;
        end else begin
            readbackValid <= readReq;
            if (readReq) begin
                readbackData <= word;
            end
        end
    end
endmodule // pdrlc_readback
`default_nettype wire

// ---- design/pdrlc_top.sv ----
// Register bank, calibration cache and DAC load sequencing for four channels
`timescale 1ns/1ps
`default_nettype none
module pdrlc_top (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire pdrlc_pkg::pdrlc_req_type hostReq,
    input wire logic thermalAlarmIn,
    output logic [23:0] readbackData,
    output logic readbackValid,
    output pdrlc_pkg::pdrlc_dac_set_type [3:0] dacLevel,
    output logic [15:0] offsetDacLevel,
    output logic [3:0][21:0] channelConfig,
    output logic [3:0] forceSwitchClosed,
    output logic [21:0] systemControl,
    output logic thermalShutdownEn,
    output logic thermalAlarmLatched
);
    // Slot storage, index is channel and kind
    logic [15:0] gainReg [64]; // Gain coefficients
    logic [15:0] offsetReg [64]; // Offset coefficients
    logic [15:0] inputReg [64]; // Input codes
    logic [15:0] corrReg [64]; // Cached corrected codes

    // Device-wide registers
    logic [21:0] sysctl_reg; // System control
    logic [3:0][21:0] cfg_reg; // Channel configuration
    logic [23:0] alarm_reg; // Alarm status
    logic [23:0] compare_reg; // Comparator status
    logic alarmLive_reg; // Thermal alarm live copy
    logic alarmLatched_reg; // Thermal alarm latch
    logic [15:0] offsetDac_reg; // Shared offset DAC level
    logic alarmLatched_next; // Latch next value

    // Request decode
    logic wrReq; // Any write
    logic wrGain; // Gain coefficient write
    logic wrOffset; // Offset coefficient write
    logic wrInput; // Input code write
    logic wrSys; // System control write
    logic wrCfg; // Channel configuration write
    logic rdReq; // Any read
    logic [1:0] slotChan; // Channel of a slot address
    logic [3:0] slotKind; // Kind of a slot address
    logic [15:0] corrValue; // Corrected code of the incoming input
    logic [23:0] rawWord; // Unformatted readback source

    // Decode of the single request port
    always_comb begin
        wrReq = hostReq.valid && hostReq.isWrite;
        rdReq = hostReq.valid && !hostReq.isWrite;
        wrGain = wrReq && hostReq.target == pdrlc_pkg::TGT_GAIN;
        wrOffset = wrReq && hostReq.target == pdrlc_pkg::TGT_OFFSET;
        wrInput = wrReq && hostReq.target == pdrlc_pkg::TGT_INPUT;
        wrSys = wrReq && hostReq.target == pdrlc_pkg::TGT_SYSCTL;
        wrCfg = wrReq && hostReq.target == pdrlc_pkg::TGT_CHANCFG;
        slotChan = hostReq.addr[5:4];
        slotKind = hostReq.addr[3:0];
    end

    // Corrector fed with the coefficients of the addressed slot
    pdrlc_cal_engine calEngine (
        .inputCode(hostReq.data[15:0]),
        .gainCoef(gainReg[hostReq.addr]),
        .offsetCoef(offsetReg[hostReq.addr]),
        .correctedCode(corrValue)
    );

    // Per-slot storage
    genvar e;
    generate
        for (e = 0; e < 64; e++) begin : gSlot
            // Reset value of this slot's input code
            localparam logic [15:0] X1_RST = pdrlc_pkg::x1Default(4'(e));

            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    gainReg[e] <= pdrlc_pkg::GAIN_RST;
                    offsetReg[e] <= pdrlc_pkg::OFFSET_RST;
                end else begin
                    // Coefficient loads
                    if (wrGain && hostReq.addr == 6'(e)) begin
                        gainReg[e] <= hostReq.data[15:0];
                    end
                    if (wrOffset && hostReq.addr == 6'(e)) begin
                        offsetReg[e] <= hostReq.data[15:0];
                    end
                end
            end

            // input defaults, one code per range slot
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    inputReg[e] <= X1_RST;
                end else if (wrInput && hostReq.addr == 6'(e)) begin
                    inputReg[e] <= hostReq.data[15:0];
                end
            end

            // cache corrected code in the same cycle
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    corrReg[e] <= X1_RST;
                end else if (wrInput && hostReq.addr == 6'(e)) begin
                    corrReg[e] <= corrValue;
                end
            end
        end
    endgenerate

    // system control with thermal enable default
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sysctl_reg <= pdrlc_pkg::SYSCTL_RST;
        end else if (wrSys) begin
            sysctl_reg <= hostReq.data;
        end
    end

    // Shared offset DAC follows the corrected code of channel 0's offset slot at once
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            offsetDac_reg <= pdrlc_pkg::OFFSET_DAC_RST;
        end else if (wrInput && slotChan == 2'h0 && slotKind == pdrlc_pkg::K_OFFSET_DAC) begin
            offsetDac_reg <= corrValue;
        end
    end

    // Thermal alarm latch, set wins over clear
    always_comb begin
        alarmLatched_next = alarmLatched_reg;
        // clear by a one in bit 6 of any channel write
        if (wrCfg && hostReq.data[pdrlc_pkg::CFG_TALM_CLR_BIT]) begin
            alarmLatched_next = 1'b0;
        end
        // An event in the clear cycle survives
        if (thermalAlarmIn) begin
            alarmLatched_next = 1'b1;
        end
    end

    // Thermal alarm state
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            alarmLive_reg <= 1'b1;
            alarmLatched_reg <= 1'b1;
        end else begin
            alarmLive_reg <= thermalAlarmIn;
            alarmLatched_reg <= alarmLatched_next;
        end
    end

    // alarm status register, thermal bits tracked
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            alarm_reg <= pdrlc_pkg::ALARM_RST;
        end else begin
            alarm_reg[pdrlc_pkg::ALM_LATCHED_BIT] <= alarmLatched_next;
            alarm_reg[pdrlc_pkg::ALM_LIVE_BIT] <= thermalAlarmIn;
        end
    end

    // comparator status holds its power-on word
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            compare_reg <= pdrlc_pkg::COMPARE_RST;
        end else begin
            compare_reg <= compare_reg;
        end
    end

    // Per-channel configuration and DAC loading
    genvar c;
    generate
        for (c = 0; c < 4; c++) begin : gChan
            logic cfgWr; // Write to this channel's configuration
            logic [21:0] cfgSel; // Configuration that picks the slots
            logic [1:0] fsel; // Force select field
            logic [2:0] range; // Current range field
            logic hiZ; // High-impedance force mode
            logic fvClamp; // Voltage forcing with current clamps
            logic [3:0] forceKind; // Selected force slot
            logic [3:0] lowKind; // Selected low clamp slot
            logic [3:0] highKind; // Selected high clamp slot
            logic [3:0] cmpLowKind; // Selected low comparator slot
            logic [3:0] cmpHighKind; // Selected high comparator slot
            logic inWr; // Input write aimed at this channel

            // Slot selection from the new or the standing mode
            always_comb begin
                cfgWr = wrCfg && hostReq.addr[1:0] == 2'(c);
                cfgSel = cfgWr ? hostReq.data : cfg_reg[c];
                fsel = cfgSel[pdrlc_pkg::CFG_FSEL_HI:pdrlc_pkg::CFG_FSEL_LO];
                range = cfgSel[pdrlc_pkg::CFG_RANGE_HI:pdrlc_pkg::CFG_RANGE_LO];
                if (range > pdrlc_pkg::MAX_CUR_RANGE) begin
                    range = pdrlc_pkg::MAX_CUR_RANGE;
                end
                hiZ = fsel == pdrlc_pkg::FSEL_HIZ_V || fsel == pdrlc_pkg::FSEL_HIZ_I;
                fvClamp = fsel == pdrlc_pkg::FSEL_FV && cfgSel[pdrlc_pkg::CFG_CLAMP_BIT];
                inWr = wrInput && slotChan == 2'(c);
                // voltage modes and current modes each name their own slots
                if (fsel == pdrlc_pkg::FSEL_FV || fsel == pdrlc_pkg::FSEL_HIZ_V) begin
                    // Voltage forcing uses current clamps
                    forceKind = pdrlc_pkg::K_FIN_V;
                    lowKind = pdrlc_pkg::K_CLL_I;
                    highKind = pdrlc_pkg::K_CLH_I;
                end else begin
                    // Current forcing uses voltage clamps
                    forceKind = pdrlc_pkg::K_FIN_I0 + {1'b0, range};
                    lowKind = pdrlc_pkg::K_CLL_V;
                    highKind = pdrlc_pkg::K_CLH_V;
                end
                if (cfgSel[pdrlc_pkg::CFG_CMP_I_BIT]) begin
                    // Comparing current
                    cmpLowKind = pdrlc_pkg::K_CPL_I;
                    cmpHighKind = pdrlc_pkg::K_CPH_I;
                end else begin
                    // Comparing voltage
                    cmpLowKind = pdrlc_pkg::K_CPL_V;
                    cmpHighKind = pdrlc_pkg::K_CPH_V;
                end
            end

            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    cfg_reg[c] <= pdrlc_pkg::CHANCFG_RST;
                end else if (cfgWr) begin
                    cfg_reg[c] <= hostReq.data;
                end
            end

            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    dacLevel[c] <= {pdrlc_pkg::FIN_RST, pdrlc_pkg::LOW_RST, pdrlc_pkg::HIGH_RST,
                                    pdrlc_pkg::LOW_RST, pdrlc_pkg::HIGH_RST};
                end else if (cfgWr) begin
                    // transfer cached codes, equal levels stay
                    dacLevel[c].forceLevel <= corrReg[{2'(c), forceKind}];
                    dacLevel[c].clampLow <= corrReg[{2'(c), lowKind}];
                    dacLevel[c].clampHigh <= corrReg[{2'(c), highKind}];
                    dacLevel[c].compareLow <= corrReg[{2'(c), cmpLowKind}];
                    dacLevel[c].compareHigh <= corrReg[{2'(c), cmpHighKind}];
                end else if (inWr) begin
                    // high-impedance direct load of force level
                    if (hiZ && slotKind == forceKind) begin
                        dacLevel[c].forceLevel <= corrValue;
                    end
                    // clamps load directly in high-impedance modes, or when forcing voltage with the clamp bit set
                    if ((hiZ || fvClamp) && slotKind == lowKind) begin
                        dacLevel[c].clampLow <= corrValue;
                    end
                    if ((hiZ || fvClamp) && slotKind == highKind) begin
                        dacLevel[c].clampHigh <= corrValue;
                    end
                end
            end

            // high-impedance modes open the output switch
            assign forceSwitchClosed[c] = !cfg_reg[c][pdrlc_pkg::CFG_FSEL_HI];
        end
    endgenerate

    // Readback source selection
    always_comb begin
        rawWord = 24'h000000;
        unique case (hostReq.target)
            pdrlc_pkg::TGT_GAIN: rawWord = {8'h00, gainReg[hostReq.addr]};
            pdrlc_pkg::TGT_OFFSET: rawWord = {8'h00, offsetReg[hostReq.addr]};
            pdrlc_pkg::TGT_INPUT: rawWord = {8'h00, inputReg[hostReq.addr]};
            pdrlc_pkg::TGT_SYSCTL: rawWord = {2'b00, sysctl_reg};
            pdrlc_pkg::TGT_CHANCFG: begin
                // Thermal status shows in bits 6 and 5
                rawWord = {2'b00, cfg_reg[hostReq.addr[1:0]]};
                rawWord[pdrlc_pkg::CFG_TALM_CLR_BIT] = alarmLatched_reg;
                rawWord[pdrlc_pkg::CFG_TALM_LIVE_BIT] = alarmLive_reg;
            end
            pdrlc_pkg::TGT_ALARM: rawWord = alarm_reg;
            pdrlc_pkg::TGT_COMPARE: rawWord = compare_reg;
            // Unused target code
            default: rawWord = 24'h000000;
        endcase
    end

    // Registered readback answer
    pdrlc_readback readback (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .readReq(rdReq),
        .target(hostReq.target),
        .addr(hostReq.addr),
        .rawWord(rawWord),
        .readbackData(readbackData),
        .readbackValid(readbackValid)
    );

    // Level, configuration and status outputs
    assign offsetDacLevel = offsetDac_reg;
    assign channelConfig = cfg_reg;
    assign systemControl = sysctl_reg;
    assign thermalShutdownEn = sysctl_reg[pdrlc_pkg::SYS_THERM_EN_BIT];
    assign thermalAlarmLatched = alarmLatched_reg;

endmodule // pdrlc_top
`default_nettype wire

// ---- bench/pdrlc_checker.sv ----
// Port assertions for the DAC register bank
`timescale 1ns/1ps
`default_nettype none
module pdrlc_checker (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire pdrlc_pkg::pdrlc_req_type hostReq,
    input wire logic thermalAlarmIn,
    input wire logic [23:0] readbackData,
    input wire logic readbackValid,
    input wire pdrlc_pkg::pdrlc_dac_set_type [3:0] dacLevel,
    input wire logic [15:0] offsetDacLevel,
    input wire logic [3:0][21:0] channelConfig,
    input wire logic [3:0] forceSwitchClosed,
    input wire logic [21:0] systemControl,
    input wire logic thermalShutdownEn,
    input wire logic thermalAlarmLatched
);
    // Read and configuration write decode
    logic rd;
    logic cfg0;
    assign rd = hostReq.valid && !hostReq.isWrite;
    assign cfg0 = hostReq.valid && hostReq.isWrite && hostReq.target == pdrlc_pkg::TGT_CHANCFG
        && hostReq.addr[1:0] == 2'h0;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    chk_rb_pulse: assert property (rd |=> readbackValid)
        else $error("read without readback pulse");
    chk_rb_gain: assert property (rd && hostReq.target == pdrlc_pkg::TGT_GAIN
        |=> readbackData[23:16] == {pdrlc_pkg::RB_TYPE_GAIN, $past(hostReq.addr)})
        else $error("gain readback header wrong");
    chk_rb_offset: assert property (rd && hostReq.target == pdrlc_pkg::TGT_OFFSET
        |=> readbackData[23:16] == {pdrlc_pkg::RB_TYPE_OFFSET, $past(hostReq.addr)})
        else $error("offset readback header wrong");
    chk_rb_input: assert property (rd && hostReq.target == pdrlc_pkg::TGT_INPUT
        |=> readbackData[23:16] == {pdrlc_pkg::RB_TYPE_INPUT, $past(hostReq.addr)})
        else $error("input readback header wrong");
    chk_switch_open: assert property (forceSwitchClosed == ~{channelConfig[3][20],
        channelConfig[2][20], channelConfig[1][20], channelConfig[0][20]})
        else $error("force switch disagrees with force select");
    chk_therm_en: assert property (thermalShutdownEn == systemControl[5])
        else $error("thermal enable not bit 5");
    chk_cfg_write: assert property (cfg0 |=> {channelConfig[0][20:19], channelConfig[0][17:15]}
        == {$past(hostReq.data[20:19]), $past(hostReq.data[17:15])})
        else $error("configuration write not applied");
    chk_alarm_set: assert property (thermalAlarmIn |=> thermalAlarmLatched)
        else $error("thermal alarm not latched");
    chk_levels_hold: assert property (!hostReq.valid |=> $stable(dacLevel)
        && $stable(offsetDacLevel))
        else $error("levels moved without a request");
endmodule // pdrlc_checker
`default_nettype wire

// ---- bench/pdrlc_host_model.sv ----
// Host controller model presenting register requests
`timescale 1ns/1ps
`default_nettype none
module pdrlc_host_model (
    input wire logic ref_clk,
    output var pdrlc_pkg::pdrlc_req_type hostReq
);
    // Idle request at time zero
    initial begin
        hostReq = '0;
    end
    // One request taken at the next rising edge
    task automatic access(input logic w, input pdrlc_pkg::pdrlc_target_type t,
        input logic [5:0] a, input logic [21:0] d);
        @(negedge ref_clk);
        hostReq = '{valid: 1'b1, isWrite: w, target: t, addr: a, data: d};
    endtask
    // Release: strobe low, stale address and data inverted
    task automatic idle();
        @(negedge ref_clk);
        hostReq.valid = 1'b0;
        hostReq.addr = ~hostReq.addr;
        hostReq.data = ~hostReq.data;
    endtask
endmodule // pdrlc_host_model
`default_nettype wire

// ---- bench/test_pmu_dac_register_load_control.sv ----
// Self-checking bench for the DAC register bank
`timescale 1ns/1ps
`default_nettype none
module test_pmu_dac_register_load_control;
    logic ref_clk;
    logic nrst;
    logic thermalAlarmIn;
    pdrlc_pkg::pdrlc_req_type hostReq;
    logic [23:0] readbackData;
    logic readbackValid;
    pdrlc_pkg::pdrlc_dac_set_type [3:0] dacLevel;
    logic [15:0] offsetDacLevel;
    logic [3:0][21:0] channelConfig;
    logic [3:0] forceSwitchClosed;
    logic [21:0] systemControl;
    logic thermalShutdownEn;
    logic thermalAlarmLatched;
    int fails;
    int checked;
    pdrlc_host_model pdrlc_host_model_i (.ref_clk(ref_clk), .hostReq(hostReq));
    pdrlc_top pdrlc_top_i (.ref_clk(ref_clk), .nrst(nrst), .hostReq(hostReq),
        .thermalAlarmIn(thermalAlarmIn), .readbackData(readbackData),
        .readbackValid(readbackValid), .dacLevel(dacLevel), .offsetDacLevel(offsetDacLevel),
        .channelConfig(channelConfig), .forceSwitchClosed(forceSwitchClosed),
        .systemControl(systemControl), .thermalShutdownEn(thermalShutdownEn),
        .thermalAlarmLatched(thermalAlarmLatched));
    // Compare and count
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Register write then release
    task automatic wr(input pdrlc_pkg::pdrlc_target_type t, input logic [5:0] a,
        input logic [21:0] d);
        pdrlc_host_model_i.access(1'b1, t, a, d);
        pdrlc_host_model_i.idle();
    endtask
    // Register read, pulse and word checked one cycle on
    task automatic rd(input pdrlc_pkg::pdrlc_target_type t, input logic [5:0] a,
        input logic [23:0] e);
        pdrlc_host_model_i.access(1'b0, t, a, 22'h0);
        pdrlc_host_model_i.idle();
        chk({23'h0, readbackValid}, 24'h1);
        chk(readbackData, e);
    endtask
    // Counts, verdict and end of run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Free-running clock
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // Hang guard
    initial begin
        repeat (4000) @(posedge ref_clk);
        fails++;
        wrap_up();
    end
    // Main sequence
    initial begin
        fails = 0;
        checked = 0;
        nrst = 1'b0;
        thermalAlarmIn = 1'b1;
        repeat (8) @(negedge ref_clk);
        nrst = 1'b1;
        chk({8'h0, dacLevel[0].forceLevel}, 24'h008000);
        chk({dacLevel[3].clampLow[7:0], dacLevel[3].clampHigh}, 24'h00ffff);
        chk({dacLevel[2].compareLow[7:0], dacLevel[2].compareHigh}, 24'h00ffff);
        chk({8'h0, offsetDacLevel}, 24'h00a492);
        chk({2'h0, systemControl}, 24'h000020);
        chk({2'h0, channelConfig[1]}, 24'h01e060);
        chk({20'h0, forceSwitchClosed}, 24'h00000f);
        rd(pdrlc_pkg::TGT_GAIN, 6'h15, {2'b01, 6'h15, 16'hffff});
        rd(pdrlc_pkg::TGT_OFFSET, 6'h2a, {2'b10, 6'h2a, 16'h8000});
        rd(pdrlc_pkg::TGT_INPUT, 6'h0e, {2'b11, 6'h0e, 16'ha492});
        rd(pdrlc_pkg::TGT_ALARM, 6'h00, 24'hfffff0);
        rd(pdrlc_pkg::TGT_COMPARE, 6'h00, 24'h400000);
        rd(pdrlc_pkg::TGT_CHANCFG, 6'h01, 24'h01e060);
        rd(pdrlc_pkg::pdrlc_target_type'(3'h7), 6'h00, 24'h000000);
        $display("reset and readback test done");
        // Setup order: system control, offset DAC code, gain coefficient, code, configuration
        wr(pdrlc_pkg::TGT_SYSCTL, 6'h00, 22'h000021);
        chk({2'h0, systemControl}, 24'h000021);
        chk({23'h0, thermalShutdownEn}, 24'h1);
        wr(pdrlc_pkg::TGT_INPUT, 6'h0e, 22'h001111);
        chk({8'h0, offsetDacLevel}, 24'h001111);
        wr(pdrlc_pkg::TGT_GAIN, 6'h10, 22'h007fff);
        pdrlc_host_model_i.access(1'b1, pdrlc_pkg::TGT_INPUT, 6'h10, 22'h001234);
        pdrlc_host_model_i.access(1'b1, pdrlc_pkg::TGT_CHANCFG, 6'h01, 22'h000000);
        pdrlc_host_model_i.idle();
        chk({8'h0, dacLevel[1].forceLevel}, 24'h00091a);
        wr(pdrlc_pkg::TGT_INPUT, 6'h01, 22'h002222);
        chk({8'h0, dacLevel[0].forceLevel}, 24'h008000);
        wr(pdrlc_pkg::TGT_CHANCFG, 6'h00, 22'h080000);
        chk({8'h0, dacLevel[0].forceLevel}, 24'h002222);
        $display("cached load test done");
        // Host opens the force switch before changing levels
        wr(pdrlc_pkg::TGT_CHANCFG, 6'h02, 22'h100000);
        chk({20'h0, forceSwitchClosed}, 24'h00000b);
        wr(pdrlc_pkg::TGT_INPUT, 6'h20, 22'h004321);
        chk({8'h0, dacLevel[2].forceLevel}, 24'h004321);
        wr(pdrlc_pkg::TGT_INPUT, 6'h26, 22'h000100);
        chk({8'h0, dacLevel[2].clampLow}, 24'h000100);
        wr(pdrlc_pkg::TGT_INPUT, 6'h2a, 22'h005555);
        chk({8'h0, dacLevel[2].compareLow}, 24'h000000);
        wr(pdrlc_pkg::TGT_CHANCFG, 6'h02, 22'h000000);
        chk({8'h0, dacLevel[2].forceLevel}, 24'h004321);
        chk({8'h0, dacLevel[2].compareLow}, 24'h005555);
        chk({20'h0, forceSwitchClosed}, 24'h00000f);
        wr(pdrlc_pkg::TGT_CHANCFG, 6'h03, 22'h000200);
        wr(pdrlc_pkg::TGT_INPUT, 6'h37, 22'h007000);
        chk({8'h0, dacLevel[3].clampHigh}, 24'h007000);
        $display("direct load test done");
        // Latched alarm survives until cleared, then sets again
        thermalAlarmIn = 1'b0;
        @(negedge ref_clk);
        chk({23'h0, thermalAlarmLatched}, 24'h1);
        wr(pdrlc_pkg::TGT_CHANCFG, 6'h00, 22'h080040);
        chk({23'h0, thermalAlarmLatched}, 24'h0);
        thermalAlarmIn = 1'b1;
        @(negedge ref_clk);
        chk({23'h0, thermalAlarmLatched}, 24'h1);
        $display("thermal latch test done");
        wrap_up();
    end
endmodule // test_pmu_dac_register_load_control
bind pdrlc_top pdrlc_checker pdrlc_checker_i (.ref_clk(ref_clk), .nrst(nrst), .hostReq(hostReq),
    .thermalAlarmIn(thermalAlarmIn), .readbackData(readbackData), .readbackValid(readbackValid),
    .dacLevel(dacLevel), .offsetDacLevel(offsetDacLevel), .channelConfig(channelConfig),
    .forceSwitchClosed(forceSwitchClosed), .systemControl(systemControl),
    .thermalShutdownEn(thermalShutdownEn), .thermalAlarmLatched(thermalAlarmLatched));
`default_nettype wire
